// [verilog/lpms_sequencer.sv]
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module lpms_sequencer
  import lpms_pkg::*;
  #(
    parameter int STACK_DEPTH = 4,
    parameter int SP_W        = 3
  )
  (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             reset,
    // Wishbone slave.
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [DAT_W-1:0] wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    output      logic [DAT_W-1:0] wb_dat_o,
    output      logic             wb_ack_o,
    // CPU side.
    input  wire logic             irq_req,
    input  wire logic             return_from_interrupt,
    input  wire logic [PC_W-1:0]  cpu_pc,
    output      logic             irq_ack_q,
    output      logic             pc_valid_q,
    output      logic [PC_W-1:0]  resume_pc_q,
    // Neighbouring modules.
    input  wire logic             watchdog_armed,
    input  wire logic             rtc_domain_enabled,
    input  wire logic             sub_clk_request,
    input  wire logic             aux_clk_request,
    // Pins from outside the clock domain.
    input  wire lpms_wake_type    wake_pins,
    input  wire logic             supply_low,
    // Power and clock controls.
    output      lpms_level_type   level_q,
    output      logic             core_reg_on_q,
    output      logic             rtc_reg_on_q,
    output      logic             supervisor_on_q,
    output      logic             cpu_run_q,
    output      logic             aux_clk_en_q,
    output      logic             sub_clk_en_q,
    output      logic             brownout_reset_q,
    output      logic             io_freeze_q,
    output      logic             pin_irq_flag_set_q,
    output      logic             rtc_irq_flag_set_q
  );

  // Two-stage synchronisers for the pins.
  lpms_wake_type wake_s1_q;  // First stage, read only by the second.
  lpms_wake_type wake_s2_q;  // Usable wake levels.
  logic          supl_s1_q;  // First stage of the supply monitor.
  logic          supl_s2_q;  // Usable supply-low level.

  // Sequencer state and its next values.
  lpms_state_type  state_q, state_d;
  lpms_status_type sw_q, sw_d;          // Live status word.
  logic [SP_W-1:0] sp_q, sp_d;          // Stack depth in use.
  logic            unlock_q, unlock_d;  // Power control write access.
  logic            regoff_q, regoff_d;  // Regulator-off request.
  logic            hse_q, hse_d;        // High supervisor enable.
  logic            wakef_q, wakef_d;    // Shutdown wake flag.
  logic            supvf_q, supvf_d;    // High supervisor flag.
  logic            refuse_q, refuse_d;  // Shutdown refused flag.
  logic [3:0]      cause_q, cause_d;    // Reset cause vector.
  logic            ack_q, ack_d;        // Bus acknowledge.
  logic [DAT_W-1:0] rdat_q, rdat_d;     // Bus read data.
  lpms_level_type  level_d;
  logic core_d, rtc_d, supon_d, run_d, aclk_d, sclk_d, bor_d;
  logic freeze_d, pinf_d, rtcf_d, iack_d, pcv_d;
  logic [PC_W-1:0] rpc_d;

  // Stack port signals.
  logic                 stk_we;
  logic [SP_W-2:0]      stk_waddr;
  logic [PC_W+SW_W-1:0] stk_wdata;
  logic [PC_W+SW_W-1:0] stk_rd;
  logic [SP_W-2:0]      stk_top;

  // Decoded bus request, taken on the edge that raises ack.
  logic bus_req, bus_wr;
  logic all_sleep, irq_take, shut_go;
  logic pw_ok;

  // Stack holds one {pc, status word} pair per nesting level.
  lpms_stack_mem #(
    .WIDTH (PC_W + SW_W),
    .DEPTH (STACK_DEPTH),
    .AW    (SP_W - 1)
  ) u_stack (
    .clk       (clk),
    .reset     (reset),
    .wr_en     (stk_we),
    .wr_addr   (stk_waddr),
    .wr_data   (stk_wdata),
    .rd_addr   (stk_top),
    .rd_data_q (stk_rd)
  );

  // Read address points at the top entry, or at entry 0 when the stack is empty.
  assign stk_top   = SP_W'(sp_q - 1'b1) < SP_W'(STACK_DEPTH) ?
                     stk_waddr_top(sp_q) : '0;
  assign bus_req   = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr    = bus_req && wb_we_i;
  assign all_sleep = sw_q.cpu_halt_bit && sw_q.oscillator_disable_bit &&
                     sw_q.clock_gen_lo_off_bit &&
                     sw_q.clock_gen_hi_off_bit;
  assign irq_take  = (state_q == ST_RUN) && irq_req &&
                     sw_q.global_irq_enable &&
                     (sp_q < SP_W'(STACK_DEPTH));
  assign shut_go   = (state_q == ST_RUN) && !irq_take && all_sleep &&
                     regoff_q && !watchdog_armed;
  assign pw_ok     = wb_sel_i[1] && (wb_dat_i[15:8] == PCTL_PASSWORD);

  // Index of the topmost stack entry.
  function automatic logic [SP_W-2:0] stk_waddr_top(logic [SP_W-1:0] sp);
    logic [SP_W-1:0] t;
    t = SP_W'(sp - 1'b1);
    return t[SP_W-2:0];
  endfunction

  // Synchronisers for everything that arrives on pins.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wake_s1_q <= '0;
      wake_s2_q <= '0;
      supl_s1_q <= 1'b0;
      supl_s2_q <= 1'b0;
    end
    else
    begin
      wake_s1_q <= wake_pins;
      wake_s2_q <= wake_s1_q;
      supl_s1_q <= supply_low;
      supl_s2_q <= supl_s1_q;
    end
  end

  // Next-state logic for the sequencer, stack and registers.
  always_comb
  begin
    state_d  = state_q;
    sw_d     = sw_q;
    sp_d     = sp_q;
    unlock_d = unlock_q;
    regoff_d = regoff_q;
    hse_d    = hse_q;
    wakef_d  = wakef_q;
    supvf_d  = supvf_q;
    refuse_d = refuse_q;
    cause_d  = cause_q;
    freeze_d = io_freeze_q;
    supon_d  = supervisor_on_q;
    bor_d    = 1'b0;
    pinf_d   = 1'b0;
    rtcf_d   = 1'b0;
    iack_d   = 1'b0;
    pcv_d    = 1'b0;
    rpc_d    = resume_pc_q;
    stk_we    = 1'b0;
    stk_waddr = sp_q[SP_W-2:0];
    stk_wdata = {cpu_pc, sw_q};
    ack_d    = bus_req;
    rdat_d   = '0;

    // Register reads present a snapshot of the current state.
    if (bus_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        OFF_STATUS: rdat_d = DAT_W'(sw_q);
        OFF_PCTL:   rdat_d = DAT_W'({hse_q, regoff_q});
        OFF_SHCTL:  rdat_d = DAT_W'(io_freeze_q);
        OFF_FLAGS:  rdat_d = DAT_W'({refuse_q, supvf_q, wakef_q});
        OFF_CAUSE:  rdat_d = DAT_W'(cause_q);
        OFF_STACK:  rdat_d = DAT_W'(stk_rd[SW_W-1:0]);
        OFF_MODE:   rdat_d = DAT_W'({sp_q, state_q, level_q});
        default:    rdat_d = '0;
      endcase
    end

    // Software writes; a hardware set in the same cycle wins later.
    if (bus_wr && wb_sel_i[0] && (state_q == ST_RUN))
    begin
      unique case (wb_adr_i)
        OFF_STATUS: sw_d = lpms_status_type'(wb_dat_i[SW_W-1:0]);
        OFF_SHCTL:  freeze_d = freeze_d &
                               wb_dat_i[SHC_FREEZE_POS];
        OFF_FLAGS:
        begin
          wakef_d  = wakef_q  & ~wb_dat_i[FLG_WAKE_POS];
          supvf_d  = supvf_q  & ~wb_dat_i[FLG_SUPV_POS];
          refuse_d = refuse_q & ~wb_dat_i[FLG_REFUSE_POS];
        end
        OFF_STACK:
        begin
          // Handler edits the stacked status word.
          stk_we    = (sp_q != '0);
          stk_waddr = stk_top;
          stk_wdata = {stk_rd[PC_W+SW_W-1:SW_W],
                       wb_dat_i[SW_W-1:0]};
        end
        default: ;
      endcase
    end
    // Password byte opens or closes access to the low byte.
    if (bus_wr && (wb_adr_i == OFF_PCTL))
    begin
      if (wb_sel_i[0] && (unlock_q || pw_ok))
      begin
        regoff_d = wb_dat_i[PCTL_REGOFF_POS];
        hse_d    = wb_dat_i[PCTL_HSE_POS];
      end
      if (wb_sel_i[1])
      begin
        unlock_d = pw_ok;
      end
    end

    // Supply monitor sets its flag while the supervisor runs.
    if (supl_s2_q && supervisor_on_q)
    begin
      supvf_d = 1'b1;
    end

    unique case (state_q)
      ST_RUN:
      begin
        supon_d = hse_q;
        if (irq_take)
        begin
          // Push pc and status word, then run the handler.
          stk_we    = 1'b1;
          stk_waddr = sp_q[SP_W-2:0];
          stk_wdata = {cpu_pc, sw_q};
          sp_d      = SP_W'(sp_q + 1'b1);
          iack_d    = 1'b1;
          sw_d = sw_q;
          sw_d.cpu_halt_bit           = 1'b0;
          sw_d.clock_gen_hi_off_bit   = 1'b0;
          sw_d.oscillator_disable_bit = 1'b0;
          sw_d.global_irq_enable      = 1'b0;
          // The low-generator bit is kept.
        end
        else if (return_from_interrupt && (sp_q != '0))
        begin
          sp_d    = SP_W'(sp_q - 1'b1);
          state_d = ST_POP;
        end
        else if (all_sleep && regoff_q && watchdog_armed)
        begin
          refuse_d = 1'b1;
        end
        else if (shut_go)
        begin
          state_d = ST_SHUT;
          supon_d = hse_q;
        end
      end
      ST_POP:
      begin
        // Stacked word, possibly edited, becomes live.
        sw_d    = lpms_status_type'(stk_rd[SW_W-1:0]);
        rpc_d   = stk_rd[PC_W+SW_W-1:SW_W];
        pcv_d   = 1'b1;
        state_d = ST_RUN;
      end
      ST_SHUT:
      begin
        if (wake_s2_q.io || wake_s2_q.rstpin ||
            (wake_s2_q.rtc && rtc_reg_on_q))
        begin
          state_d  = ST_WAKE;
          bor_d    = 1'b1;
          freeze_d = 1'b1;
          if (wake_s2_q.io)
          begin
            pinf_d  = 1'b1;
            wakef_d = 1'b1;
            cause_d = CAUSE_IO;
          end
          else if (wake_s2_q.rtc)
          begin
            rtcf_d  = 1'b1;
            wakef_d = 1'b1;
            cause_d = CAUSE_RTC;
          end
          else
          begin
            cause_d = CAUSE_RSTPIN;
          end
        end
      end
      ST_WAKE:
      begin
        // Core restarts from its reset state.
        state_d  = ST_RUN;
        sw_d     = SW_RST;
        sp_d     = '0;
        unlock_d = 1'b0;
        regoff_d = PCTL_REGOFF_RST;
        hse_d    = PCTL_HSE_RST;
      end
    endcase
  end

  // Level actually reached and the clock and power enables.
  always_comb
  begin
    level_d = LV_ACTIVE;
    if (state_q == ST_SHUT)
    begin
      level_d = rtc_reg_on_q ? LV_SHUT_RTC : LV_SHUT_FULL;
    end
    else if (shut_go)
    begin
      level_d = rtc_domain_enabled ? LV_SHUT_RTC : LV_SHUT_FULL;
    end
    else if (sw_q.cpu_halt_bit)
    begin
      // Sleep bit encoding.
      if (!sw_q.clock_gen_hi_off_bit)
        level_d = LV_ZERO;
      else if (!sw_q.clock_gen_lo_off_bit)
        level_d = LV_TWO;
      else if (!sw_q.oscillator_disable_bit)
        level_d = LV_THREE;
      else
        level_d = LV_FOUR;
      // Clock requests limit the depth.
      if (sub_clk_request)
        level_d = LV_ZERO;
      else if (aux_clk_request && (level_d == LV_FOUR))
        level_d = LV_THREE;
    end
    core_d = !(level_d inside {LV_SHUT_RTC, LV_SHUT_FULL});
    rtc_d  = (level_d != LV_SHUT_FULL);
    run_d  = (level_d == LV_ACTIVE);
    aclk_d = core_d && (level_d != LV_FOUR);
    sclk_d = (level_d == LV_ACTIVE) || (level_d == LV_ZERO);
  end

  // All registers of the block apart from the pin synchronisers.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_RUN;
      sw_q    <= SW_RST;
      sp_q    <= '0;
      unlock_q <= 1'b0;
      regoff_q <= PCTL_REGOFF_RST;
      hse_q    <= PCTL_HSE_RST;
      wakef_q  <= 1'b0;
      supvf_q  <= 1'b0;
      refuse_q <= 1'b0;
      cause_q  <= CAUSE_NONE;
      ack_q    <= 1'b0;
      rdat_q   <= '0;
      level_q  <= LV_ACTIVE;
      core_reg_on_q   <= 1'b1;
      rtc_reg_on_q    <= 1'b1;
      supervisor_on_q <= PCTL_HSE_RST;
      cpu_run_q       <= 1'b1;
      aux_clk_en_q    <= 1'b1;
      sub_clk_en_q    <= 1'b1;
      brownout_reset_q <= 1'b0;
      io_freeze_q      <= 1'b0;
      pin_irq_flag_set_q <= 1'b0;
      rtc_irq_flag_set_q <= 1'b0;
      irq_ack_q   <= 1'b0;
      pc_valid_q  <= 1'b0;
      resume_pc_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      sw_q    <= sw_d;
      sp_q    <= sp_d;
      unlock_q <= unlock_d;
      regoff_q <= regoff_d;
      hse_q    <= hse_d;
      wakef_q  <= wakef_d;
      supvf_q  <= supvf_d;
      refuse_q <= refuse_d;
      cause_q  <= cause_d;
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
      level_q  <= level_d;
      core_reg_on_q   <= core_d;
      rtc_reg_on_q    <= rtc_d;
      supervisor_on_q <= supon_d;
      cpu_run_q       <= run_d;
      aux_clk_en_q    <= aclk_d;
      sub_clk_en_q    <= sclk_d;
      brownout_reset_q <= bor_d;
      io_freeze_q      <= freeze_d;
      pin_irq_flag_set_q <= pinf_d;
      rtc_irq_flag_set_q <= rtcf_d;
      irq_ack_q   <= iack_d;
      pc_valid_q  <= pcv_d;
      resume_pc_q <= rpc_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Checks on the sequencer.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_wake_exit;
    (state_q == ST_WAKE) && brownout_reset_q && io_freeze_q ##1
    (state_q == ST_RUN) && !brownout_reset_q && (sw_q == SW_RST);
  endsequence

  a_irq_ack_given: assert property (irq_take |=> irq_ack_q)
    else $error("enabled interrupt not acknowledged");
  a_irq_push_depth: assert property
    (irq_take |=> sp_q == SP_W'($past(sp_q) + 1'b1))
    else $error("interrupt entry did not push the stack");
  a_irq_bits_clear: assert property (irq_ack_q |->
    !sw_q.cpu_halt_bit && !sw_q.clock_gen_hi_off_bit &&
    !sw_q.oscillator_disable_bit)
    else $error("sleep bits survived interrupt entry");
  a_irq_lo_kept: assert property (irq_take |=>
    sw_q.clock_gen_lo_off_bit == $past(sw_q.clock_gen_lo_off_bit))
    else $error("low generator bit changed on entry");
  a_pop_restore: assert property ((state_q == ST_POP) |=>
    (sw_q == $past(stk_rd[SW_W-1:0])) && pc_valid_q)
    else $error("return did not restore the status word");
  a_watchdog_block: assert property
    ((state_q == ST_RUN) && watchdog_armed |=> state_q != ST_SHUT)
    else $error("shutdown entered with watchdog armed");
  a_shut_choice: assert property (shut_go |=>
    level_q == ($past(rtc_domain_enabled) ? LV_SHUT_RTC : LV_SHUT_FULL))
    else $error("wrong shutdown mode chosen");
  a_shut_power: assert property ((state_q == ST_SHUT)[*2] |->
    !core_reg_on_q && (rtc_reg_on_q == (level_q == LV_SHUT_RTC)))
    else $error("regulators wrong in shutdown");
  a_wake_brownout: assert property
    ((state_q == ST_SHUT) && (state_d == ST_WAKE) |=> s_wake_exit)
    else $error("shutdown exit without brownout reset");
  a_pw_guard: assert property (bus_wr && (wb_adr_i == OFF_PCTL) &&
    !unlock_q && !pw_ok |=> $stable(regoff_q))
    else $error("power control written without password");

endmodule

// [pkg/lpms_pkg.sv]
package lpms_pkg;

  // Bus geometry of the register window.
  localparam int ADR_W = 5;
  localparam int DAT_W = 32;
  // Register byte offsets.
  localparam logic [ADR_W-1:0] OFF_STATUS = 5'h00;
  localparam logic [ADR_W-1:0] OFF_PCTL   = 5'h04;
  localparam logic [ADR_W-1:0] OFF_SHCTL  = 5'h08;
  localparam logic [ADR_W-1:0] OFF_FLAGS  = 5'h0C;
  localparam logic [ADR_W-1:0] OFF_CAUSE  = 5'h10;
  localparam logic [ADR_W-1:0] OFF_STACK  = 5'h14;
  localparam logic [ADR_W-1:0] OFF_MODE   = 5'h18;

  // Password that opens the power control register; value is arbitrary.
  localparam logic [7:0] PCTL_PASSWORD = 8'h5A;
  // Power control low byte field positions and reset values.
  localparam int PCTL_REGOFF_POS = 0;
  localparam int PCTL_HSE_POS    = 1;
  localparam logic PCTL_REGOFF_RST = 1'b0;
  localparam logic PCTL_HSE_RST    = 1'b1;
  // Flag register field positions.
  localparam int FLG_WAKE_POS   = 0;
  localparam int FLG_SUPV_POS   = 1;
  localparam int FLG_REFUSE_POS = 2;
  // Shutdown control field position.
  localparam int SHC_FREEZE_POS = 0;

  // Reset cause codes.
  localparam logic [3:0] CAUSE_NONE   = 4'h0;
  localparam logic [3:0] CAUSE_RSTPIN = 4'h1;
  localparam logic [3:0] CAUSE_IO     = 4'h2;
  localparam logic [3:0] CAUSE_RTC    = 4'h3;

  // Status word as the CPU holds it.
  typedef struct packed {
    logic       clock_gen_hi_off_bit;
    logic       clock_gen_lo_off_bit;
    logic       oscillator_disable_bit;
    logic       cpu_halt_bit;
    logic       global_irq_enable;
    logic [2:0] spare;
  } lpms_status_type;

  localparam int SW_W = $bits(lpms_status_type);
  localparam int PC_W = 16;
  localparam lpms_status_type SW_RST = '0;

  // Wake pins, carried together.
  typedef struct packed {
    logic io;
    logic rtc;
    logic rstpin;
  } lpms_wake_type;

  // Level actually reached by the device.
  typedef enum logic [2:0] {
    LV_ACTIVE, LV_ZERO, LV_TWO, LV_THREE, LV_FOUR,
    LV_SHUT_RTC, LV_SHUT_FULL
  } lpms_level_type;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_RUN, ST_POP, ST_SHUT, ST_WAKE
  } lpms_state_type;

endpackage

// [verilog/lpms_stack_mem.sv]
`timescale 1ns/1ps
// Small stack memory with registered read data.
module lpms_stack_mem
  #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4,
    parameter int AW    = 2
  )
  (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             reset,
    // Write port.
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read port.
    input  wire logic [AW-1:0]    rd_addr,
    output      logic [WIDTH-1:0] rd_data_q
  );

  // Storage array; contents are undefined until written.
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Writes land in the array on the clock edge.
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read data is always registered, one cycle after the address.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule

// [dv/lpms_cpu_model.sv]
`timescale 1ns/1ps
// Behavioural CPU that raises an interrupt and returns when told to.
module lpms_cpu_model
  import lpms_pkg::*;
  (
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            reset,
    // Commands from the bench.
    input  wire logic            fire,
    input  wire logic            ret,
    // Design side.
    input  wire logic            irq_ack_q,
    output      logic            irq_req,
    output      logic            return_from_interrupt,
    output      logic [PC_W-1:0] cpu_pc
  );
  // The program counter offered for stacking stays fixed.
  assign cpu_pc = 16'hBEEF;
  // The request is held until the design takes it, as a real core would.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_req               <= 1'b0;
      return_from_interrupt <= 1'b0;
    end
    else
    begin
      irq_req               <= fire | (irq_req & ~irq_ack_q);
      return_from_interrupt <= ret;
    end
  end
endmodule

// [dv/lpms_sequencer_bench.sv]
`timescale 1ns/1ps
module lpms_sequencer_bench;
  import lpms_pkg::*;
  // A sleep row: status byte, clock requests and the level reached.
  typedef struct packed {
    logic [7:0]     st;
    logic           sub;
    logic           aux;
    lpms_level_type lv;
  } lpms_row_type;
  // A shutdown row: watchdog, RTC domain, wake pins, level and cause.
  typedef struct packed {
    logic           wd;
    logic           rtc;
    lpms_wake_type  wk;
    lpms_level_type lv;
    logic [3:0]     cs;
  } lpms_shut_type;
  logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, fire, ret;
  logic irq_req, return_from_interrupt, irq_ack_q, pc_valid_q;
  logic watchdog_armed, rtc_domain_enabled, sub_clk_request;
  logic aux_clk_request, supply_low, core_reg_on_q, rtc_reg_on_q;
  logic supervisor_on_q, cpu_run_q, aux_clk_en_q, sub_clk_en_q;
  logic brownout_reset_q, io_freeze_q;
  logic pin_irq_flag_set_q, rtc_irq_flag_set_q;
  logic [ADR_W-1:0] wb_adr_i;
  logic [DAT_W-1:0] wb_dat_i, wb_dat_o, r;
  logic [3:0]       wb_sel_i;
  logic [PC_W-1:0]  cpu_pc, resume_pc_q;
  lpms_wake_type    wake_pins;
  lpms_level_type   level_q;
  int               mismatches, compares;
  // Sleep encodings, including the clock-request limits.
  lpms_row_type rows [8] = '{'{8'h00, 0, 0, LV_ACTIVE},
    '{8'h10, 0, 0, LV_ZERO}, '{8'h90, 0, 0, LV_TWO},
    '{8'hD0, 0, 0, LV_THREE}, '{8'hF0, 0, 0, LV_FOUR},
    '{8'hF0, 0, 1, LV_THREE}, '{8'hD0, 1, 0, LV_ZERO},
    '{8'hF0, 1, 1, LV_ZERO}};
  // Shutdown cases: refused by the watchdog, then each wake source.
  lpms_shut_type shuts [4] = '{'{1, 0, 3'h0, LV_FOUR, CAUSE_NONE},
    '{0, 1, 3'h2, LV_SHUT_RTC, CAUSE_RTC},
    '{0, 0, 3'h4, LV_SHUT_FULL, CAUSE_IO},
    '{0, 1, 3'h1, LV_SHUT_RTC, CAUSE_RSTPIN}};
  // The design and its CPU partner.
  lpms_sequencer DUT (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .irq_req,
    .return_from_interrupt, .cpu_pc, .irq_ack_q, .pc_valid_q,
    .resume_pc_q, .watchdog_armed, .rtc_domain_enabled, .sub_clk_request,
    .aux_clk_request, .wake_pins, .supply_low, .level_q, .core_reg_on_q,
    .rtc_reg_on_q, .supervisor_on_q, .cpu_run_q, .aux_clk_en_q,
    .sub_clk_en_q, .brownout_reset_q, .io_freeze_q, .pin_irq_flag_set_q,
    .rtc_irq_flag_set_q);
  lpms_cpu_model cpu (.clk, .reset, .fire, .ret, .irq_ack_q, .irq_req,
    .return_from_interrupt, .cpu_pc);
  // The clock toggles every half period of 25 ns.
  always #25 clk = ~clk;
  // Compares the value got against the one expected and counts it.
  task automatic chk(input logic [DAT_W-1:0] g, input logic [DAT_W-1:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
    end
  endtask
  // One classic Wishbone cycle; read data lands in r.
  task automatic bus(input logic w, input logic [ADR_W-1:0] a,
                     input logic [DAT_W-1:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    // Data is taken and the request released at the edge that sees ack.
    chk({31'h0, wb_ack_o}, 32'h1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Waits a bounded time for a design output to go high.
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, s}, 32'h1);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cuts a hang short well after the tests should be over.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  // Main sequence.
  initial
  begin
    {clk, wb_cyc_i, wb_stb_i, wb_we_i, fire, ret, supply_low} = '0;
    {watchdog_armed, rtc_domain_enabled, sub_clk_request} = '0;
    {aux_clk_request, wb_adr_i, wb_dat_i, wb_sel_i, wake_pins} = '0;
    {mismatches, compares} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk({28'h0, level_q, core_reg_on_q}, 32'h1);
    bus(0, OFF_PCTL, 32'h0, 4'hF);
    chk(r, 32'h2);
    bus(1, OFF_PCTL, 32'h1, 4'h1);
    bus(0, OFF_PCTL, 32'h0, 4'hF);
    chk(r, 32'h2);
    bus(1, 5'h1C, 32'hFF, 4'hF);
    bus(0, 5'h1C, 32'h0, 4'hF);
    chk(r, 32'h0);
    $display("test reset done");
    foreach (rows[i])
    begin
      sub_clk_request <= rows[i].sub;
      aux_clk_request <= rows[i].aux;
      bus(1, OFF_STATUS, {24'h0, rows[i].st}, 4'h1);
      repeat (2) @(negedge clk);
      chk({29'h0, level_q}, {29'h0, rows[i].lv});
      chk({29'h0, cpu_run_q, aux_clk_en_q, sub_clk_en_q},
          {29'h0, (rows[i].lv == LV_ACTIVE), (rows[i].lv != LV_FOUR),
           (rows[i].lv inside {LV_ACTIVE, LV_ZERO})});
    end
    {sub_clk_request, aux_clk_request} <= 2'b00;
    $display("test sleep levels done");
    bus(1, OFF_STATUS, 32'hF8, 4'h1);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wait_hi(irq_ack_q);
    repeat (2) @(negedge clk);
    chk({29'h0, level_q}, {29'h0, LV_ACTIVE});
    bus(0, OFF_STATUS, 32'h0, 4'hF);
    chk(r, 32'h40);
    bus(0, OFF_STACK, 32'h0, 4'hF);
    chk(r, 32'hF8);
    bus(1, OFF_STACK, 32'h18, 4'h1);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    wait_hi(pc_valid_q);
    chk({16'h0, resume_pc_q}, 32'hBEEF);
    bus(0, OFF_STATUS, 32'h0, 4'hF);
    chk(r, 32'h18);
    bus(1, OFF_STATUS, 32'h0, 4'h1);
    $display("test interrupt done");
    foreach (shuts[i])
    begin
      watchdog_armed     <= shuts[i].wd;
      // Pin selects, wake arming and oscillator halving are software
      // steps done before entry; none of them reaches this block.
      rtc_domain_enabled <= shuts[i].rtc;
      bus(1, OFF_PCTL, 32'h5A01, 4'h3);
      bus(1, OFF_PCTL, 32'h0, 4'h2);
      bus(1, OFF_PCTL, 32'h3, 4'h1);
      bus(0, OFF_PCTL, 32'h0, 4'hF);
      chk(r, 32'h1);
      bus(1, OFF_STATUS, 32'hF0, 4'h1);
      repeat (2) @(negedge clk);
      chk({29'h0, level_q}, {29'h0, shuts[i].lv});
      if (shuts[i].wd)
      begin
        bus(0, OFF_FLAGS, 32'h0, 4'hF);
        chk(r & 32'h4, 32'h4);
        bus(1, OFF_STATUS, 32'h0, 4'h1);
      end
      else
      begin
        chk({29'h0, core_reg_on_q, rtc_reg_on_q, supervisor_on_q},
            {29'h0, 1'b0, shuts[i].rtc, 1'b0});
        @(posedge clk);
        wake_pins <= shuts[i].wk;
        wait_hi(brownout_reset_q);
        chk({29'h0, io_freeze_q, pin_irq_flag_set_q, rtc_irq_flag_set_q},
            {29'h0, 1'b1, shuts[i].wk[2:1]});
        @(posedge clk);
        wake_pins <= '0;
        @(negedge clk);
        chk({30'h0, core_reg_on_q, brownout_reset_q}, 32'h2);
        bus(0, OFF_CAUSE, 32'h0, 4'hF);
        chk(r, {28'h0, shuts[i].cs});
        bus(0, OFF_FLAGS, 32'h0, 4'hF);
        if (!shuts[i].wk.rstpin) chk(r & 32'h1, 32'h1);
        bus(0, OFF_SHCTL, 32'h0, 4'hF);
        chk(r, 32'h1);
        bus(1, OFF_SHCTL, 32'h0, 4'h1);
        bus(0, OFF_SHCTL, 32'h0, 4'hF);
        chk({r[30:0], io_freeze_q}, 32'h0);
      end
      bus(1, OFF_FLAGS, 32'h7, 4'h1);
      $display("test shutdown row %0d done", i);
    end
    // A supply dip while the supervisor runs latches its flag.
    supply_low <= 1'b1;
    repeat (4) @(posedge clk);
    supply_low <= 1'b0;
    bus(0, OFF_FLAGS, 32'h0, 4'hF);
    chk(r & 32'h2, 32'h2);
    $display("test supervisor flag done");
    // A second reset in mid-run clears every flag and restarts active.
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk({28'h0, level_q, core_reg_on_q}, 32'h1);
    bus(0, OFF_FLAGS, 32'h0, 4'hF);
    chk(r, 32'h0);
    $display("test reset again done");
    wrap_up();
  end
endmodule
